/* rtl/pfl_pkg.sv */
package pfl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] RI_TBC = 10'h1c0;
    localparam logic [9:0] RI_CNT = 10'h1c2;
    localparam logic [9:0] RI_PER = 10'h1c4;
    localparam logic [9:0] RI_CMP = 10'h1c6;
    localparam logic [9:0] RI_PMC = 10'h1c8;
    localparam logic [9:0] RI_UPD = 10'h1ca;
    localparam logic [9:0] RI_DTC = 10'h1cc;
    localparam logic [9:0] RI_FLT = 10'h1d0;
    localparam logic [9:0] RI_OVD = 10'h1d4;
    localparam logic [9:0] RI_DC1 = 10'h1d6;
    localparam logic [9:0] RI_DC2 = 10'h1d8;
    localparam logic [9:0] RI_DC3 = 10'h1da;
    localparam logic [9:0] RI_STAT = 10'h1dc;
    localparam logic [9:0] RI_CFG = 10'h1de;
    // Reset values
    localparam logic [15:0] RV_ZERO = 16'h0000;
    localparam logic [15:0] RV_PER = 16'h3fff;
    localparam logic [15:0] RV_PMC = 16'h0077;
    localparam logic [15:0] RV_OVD = 16'h3f00;
    localparam logic [1:0] RV_CFG = 2'h3;
    localparam logic SYNC_RST = 1'b1;
    // Field positions
    localparam int B_TB_EN = 15;
    localparam int B_IDLE = 13;
    localparam int B_SEV_DIR = 15;
    localparam int B_LOCK = 0;
    localparam int PS_LSB = 8;
    localparam int B_FMODE = 7;
    localparam int FST_LSB = 8;
    localparam int PEN_H_LSB = 4;
    localparam int B_HIGH_SIDE_POLARITY = 0;
    localparam int B_LOW_SIDE_POLARITY = 1;
    localparam int B_FLAG = 0;
    localparam int B_FPIN = 1;
    localparam int B_FOVR = 2;
    // Time base counting modes
    typedef enum logic [1:0] {
        PFL_TB_FREE = 2'b00,
        PFL_TB_SINGLE = 2'b01,
        PFL_TB_UPDN = 2'b10,
        PFL_TB_UPDN2 = 2'b11
    } pfl_tbmode_t;
endpackage

/* rtl/pfl_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pfl_sync
    import pfl_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset
    input wire logic d_i, // Asynchronous pin
    output logic q_o // Filtered level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pfl_sync_t;
    pfl_sync_t q, n;
    // Level moves only once stages two and three agree
    always_comb begin
        n = q;
        n.s1 = d_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.lvl = q.s3;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= {4{SYNC_RST}};
        end else begin
            q <= n;
        end
    end
    assign q_o = q.lvl;
endmodule // pfl_sync
`default_nettype wire

/* rtl/pfl_postscale.sv */
`timescale 1ns/1ns
`default_nettype none
module pfl_postscale
    import pfl_pkg::*;
#(
    parameter int PW = 4
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset
    input wire logic clr_i, // Clear the count
    input wire logic hit_i, // Compare match
    input wire logic [PW-1:0] ratio_i, // Matches minus one
    output logic pulse_o // Trigger pulse
);
    typedef struct packed {
        logic [PW-1:0] cnt;
        logic pulse;
    } pfl_ps_t;
    pfl_ps_t q, n;
    // Clear beats a match in the same cycle
    always_comb begin
        n = q;
        n.pulse = 1'b0;
        if (clr_i) begin
            n.cnt = '0;
        end else if (hit_i) begin
            if (q.cnt >= ratio_i) begin
                n.cnt = '0;
                n.pulse = 1'b1;
            end else begin
                n.cnt = q.cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
    assign pulse_o = q.pulse;
endmodule // pfl_postscale
`default_nettype wire

/* rtl/pfl_top.sv */
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module pfl_top
    import pfl_pkg::*;
#(
    parameter int NPAIR = 3,
    parameter int PSW = 4
) (
    input wire logic clk_i, // 25 MHz system clock
    input wire logic rst_i, // Sync reset, high
    input wire logic [11:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [3:0] wb_sel_i, // Byte enables
    input wire logic wb_we_i, // Write strobe
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Slave select
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Access done
    input wire logic fault_input_n_i, // Fault pin, low active
    input wire logic idle_i, // CPU in idle
    input wire logic sleep_i, // CPU in sleep
    output logic [2*NPAIR-1:0] pwm_o, // Pin levels
    output logic [2*NPAIR-1:0] pwm_en_o, // Pin owned by PWM
    output logic fault_flag_o, // Fault interrupt flag
    output logic adc_trigger_o // Special event pulse
);
    localparam logic [11:0] A_TBC = {RI_TBC, 2'b00};
    localparam logic [11:0] A_CNT = {RI_CNT, 2'b00};
    localparam logic [11:0] A_PER = {RI_PER, 2'b00};
    localparam logic [11:0] A_CMP = {RI_CMP, 2'b00};
    localparam logic [11:0] A_PMC = {RI_PMC, 2'b00};
    localparam logic [11:0] A_UPD = {RI_UPD, 2'b00};
    localparam logic [11:0] A_DTC = {RI_DTC, 2'b00};
    localparam logic [11:0] A_FLT = {RI_FLT, 2'b00};
    localparam logic [11:0] A_OVD = {RI_OVD, 2'b00};
    localparam logic [11:0] A_DC1 = {RI_DC1, 2'b00};
    localparam logic [11:0] A_DC2 = {RI_DC2, 2'b00};
    localparam logic [11:0] A_DC3 = {RI_DC3, 2'b00};
    localparam logic [11:0] A_STAT = {RI_STAT, 2'b00};
    localparam logic [11:0] A_CFG = {RI_CFG, 2'b00};

    typedef struct packed {
        logic ack;
        logic [15:0] dat;
        logic [15:0] tbc;
        logic [15:0] per;
        logic [15:0] cmp;
        logic [15:0] pmc;
        logic [15:0] upd;
        logic [15:0] dtc;
        logic [15:0] flt;
        logic [15:0] ovd;
        logic [NPAIR-1:0][15:0] dc;
        logic [NPAIR-1:0][15:0] dca;
        logic [15:0] pera;
        logic [14:0] cnt;
        logic dir;
        logic flag;
        logic hold;
        logic [1:0] cfg;
        logic [2*NPAIR-1:0] pwm;
        logic [2*NPAIR-1:0] pen;
    } pfl_st_t;

    pfl_st_t q, n;
    logic fpin;
    logic fnow;
    logic req;
    logic wr;
    logic [15:0] wd;
    logic halt;
    logic run;
    logic ud;
    logic bnd_p;
    logic bnd_z;
    logic bnd;
    logic xfer;
    logic sev_hit;
    logic wr_cmp;
    logic [NPAIR-1:0] frc;
    logic [15:0] rd;

    // Fault pin through four flops; a one-cycle glitch never reaches the override
    pfl_sync u_fsync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(fault_input_n_i),
        .q_o(fpin)
    );
    assign fnow = ~fpin;

    // Bus decode; writes land on the edge that sees ack
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & q.ack;
    assign wr_cmp = wr & (wb_adr_i == A_CMP);

    // Byte-lane merge helper for 16-bit registers
    function automatic logic [15:0] merge(input logic [15:0] old);
        merge = old;
        if (wb_sel_i[0]) begin
            merge[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            merge[15:8] = wb_dat_i[15:8];
        end
    endfunction

    // Idle stops the time base only when idle-stop is set; sleep always
    assign halt = (idle_i & q.tbc[B_IDLE]) | sleep_i;
    assign run = q.tbc[B_TB_EN] & ~halt;
    assign ud = q.tbc[1];
    assign bnd_p = run & ~q.dir & (q.cnt >= q.pera[14:0]);
    assign bnd_z = run & (q.cnt == 15'h0000);
    // A disabled time base always counts as a boundary, so release is immediate
    assign bnd = bnd_p | bnd_z | ~q.tbc[B_TB_EN];

    // Buffer transfer points, all suppressed by lockout
    always_comb begin
        if (q.upd[B_LOCK]) begin
            xfer = 1'b0;
        end else if (!q.tbc[B_TB_EN]) begin
            xfer = 1'b1;
        end else if (!ud) begin
            xfer = bnd_p;
        end else if (q.tbc[1:0] == PFL_TB_UPDN2) begin
            xfer = (bnd_z & q.dir) | bnd_p;
        end else begin
            xfer = bnd_z & q.dir;
        end
    end

    // Compare match; direction only matters when counting up/down
    assign sev_hit = run & (q.cnt == q.cmp[14:0]) &
        (~ud | (q.dir == q.cmp[B_SEV_DIR]));

    // Postscaler cleared by any compare write and by reset
    pfl_postscale #(
        .PW(PSW)
    ) u_post (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(wr_cmp),
        .hit_i(sev_hit),
        .ratio_i(q.upd[PS_LSB +: PSW]),
        .pulse_o(adc_trigger_o)
    );

    // Pairs under override: only enabled ones, while fault or held
    assign frc = {NPAIR{fnow | q.hold}} & q.flt[NPAIR-1:0];

    // Read mux, if-chain decode; unmapped reads return zero
    always_comb begin
        rd = RV_ZERO;
        if (wb_adr_i == A_TBC) begin
            rd = q.tbc;
        end else if (wb_adr_i == A_CNT) begin
            rd = {q.dir, q.cnt};
        end else if (wb_adr_i == A_PER) begin
            rd = q.per;
        end else if (wb_adr_i == A_CMP) begin
            rd = q.cmp;
        end else if (wb_adr_i == A_PMC) begin
            rd = q.pmc;
        end else if (wb_adr_i == A_UPD) begin
            rd = q.upd;
        end else if (wb_adr_i == A_DTC) begin
            rd = q.dtc;
        end else if (wb_adr_i == A_FLT) begin
            rd = q.flt;
        end else if (wb_adr_i == A_OVD) begin
            rd = q.ovd;
        end else if (wb_adr_i == A_DC1) begin
            rd = q.dc[0];
        end else if (wb_adr_i == A_DC2) begin
            rd = q.dc[1];
        end else if (wb_adr_i == A_DC3) begin
            rd = q.dc[2];
        end else if (wb_adr_i == A_STAT) begin
            rd[B_FLAG] = q.flag;
            rd[B_FPIN] = fpin;
            rd[B_FOVR] = |frc;
        end else if (wb_adr_i == A_CFG) begin
            rd[1:0] = q.cfg;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        n = q;
        wd = merge(rd);
        n.ack = req & ~q.ack;
        n.dat = req ? rd : RV_ZERO;
        // Time base: free/edge or up/down, frozen while halted
        if (run) begin
            if (!ud) begin
                n.dir = 1'b0;
                n.cnt = bnd_p ? 15'h0000 : q.cnt + 15'h0001;
            end else if (!q.dir) begin
                if (bnd_p) begin
                    n.dir = 1'b1;
                    n.cnt = q.cnt - 15'h0001;
                end else begin
                    n.cnt = q.cnt + 15'h0001;
                end
            end else if (bnd_z) begin
                n.dir = 1'b0;
                n.cnt = 15'h0001;
            end else begin
                n.cnt = q.cnt - 15'h0001;
            end
        end
        // Buffered duty and period move to the active copies
        if (xfer) begin
            n.dca = q.dc;
            n.pera = q.per;
        end
        // Fault hold: engages only on enabled pairs
        if (fnow && (q.flt[NPAIR-1:0] != '0)) begin
            n.hold = 1'b1;
        end else if (q.hold && bnd && !fnow) begin
            if (q.flt[B_FMODE]) begin
                n.hold = 1'b0;
            end else if (!q.flag) begin
                n.hold = 1'b0;
            end
        end
        // Sticky flag; a fault in the clear cycle wins
        if (wr && (wb_adr_i == A_STAT) && wb_sel_i[0] && wb_dat_i[B_FLAG]) begin
            n.flag = 1'b0;
        end
        if (fnow) begin
            n.flag = 1'b1;
        end
        // Register writes
        if (wr) begin
            if (wb_adr_i == A_TBC) begin
                n.tbc = wd;
            end else if (wb_adr_i == A_CNT) begin
                n.cnt = wd[14:0];
            end else if (wb_adr_i == A_PER) begin
                n.per = wd;
            end else if (wb_adr_i == A_CMP) begin
                n.cmp = wd;
            end else if (wb_adr_i == A_PMC) begin
                n.pmc = wd;
            end else if (wb_adr_i == A_UPD) begin
                n.upd = wd;
            end else if (wb_adr_i == A_DTC) begin
                n.dtc = wd;
            end else if (wb_adr_i == A_FLT) begin
                n.flt = wd;
            end else if (wb_adr_i == A_OVD) begin
                n.ovd = wd;
            end else if (wb_adr_i == A_DC1) begin
                n.dc[0] = wd;
            end else if (wb_adr_i == A_DC2) begin
                n.dc[1] = wd;
            end else if (wb_adr_i == A_DC3) begin
                n.dc[2] = wd;
            end else if (wb_adr_i == A_CFG) begin
                n.cfg = wd[1:0];
            end
        end
        // Pin levels: compare or fault state, then side polarity
        for (int p = 0; p < NPAIR; p++) begin
            logic raw;
            logic ah;
            logic al;
            raw = q.cnt < q.dca[p][15:1];
            ah = frc[p] ? q.flt[FST_LSB + 2*p + 1] : raw;
            al = frc[p] ? q.flt[FST_LSB + 2*p] : ~raw;
            n.pwm[2*p+1] = ~(ah ^ q.cfg[B_HIGH_SIDE_POLARITY]);
            n.pwm[2*p] = ~(al ^ q.cfg[B_LOW_SIDE_POLARITY]);
            n.pen[2*p+1] = q.pmc[PEN_H_LSB + p];
            n.pen[2*p] = q.pmc[p];
        end
    end

    // State register; all outputs but adc_trigger_o come from here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.per <= RV_PER;
            q.pera <= RV_PER;
            q.pmc <= RV_PMC;
            q.ovd <= RV_OVD;
            q.cfg <= RV_CFG;
        end else begin
            q <= n;
        end
    end

    assign wb_dat_o = {16'h0000, q.dat};
    assign wb_ack_o = q.ack;
    assign pwm_o = q.pwm;
    assign pwm_en_o = q.pen;
    assign fault_flag_o = q.flag;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_no_en;
        (q.flt[NPAIR-1:0] == '0) && !q.hold |=> !q.hold;
    endproperty
    a_no_en: assert property (p_no_en) else $error("hold without enable");
    property p_latch;
        q.hold && !q.flt[B_FMODE] && q.flag |=> q.hold;
    endproperty
    a_latch: assert property (p_latch) else $error("latched release early");
    property p_early_clr;
        q.hold && fnow |=> q.hold;
    endproperty
    a_early_clr: assert property (p_early_clr) else $error("released under fault");
    property p_cbc;
        q.hold && q.flt[B_FMODE] && !fnow && bnd |=> !q.hold;
    endproperty
    a_cbc: assert property (p_cbc) else $error("cycle release missed");
    property p_lock;
        q.upd[B_LOCK] |=> $stable(q.dca) && $stable(q.pera);
    endproperty
    a_lock: assert property (p_lock) else $error("transfer under lockout");
    property p_clr;
        wr_cmp |=> !adc_trigger_o;
    endproperty
    a_clr: assert property (p_clr) else $error("postscaler not cleared");
    property p_flag;
        fnow |=> fault_flag_o ##1 fault_flag_o || !$past(fnow);
    endproperty
    a_flag: assert property (p_flag) else $error("fault flag missing");
    property p_force;
        frc[0] |=> pwm_o[1] == ~($past(q.flt[FST_LSB+1]) ^ $past(q.cfg[B_HIGH_SIDE_POLARITY]));
    endproperty
    a_force: assert property (p_force) else $error("fault level wrong");
    property p_idle;
        halt && !(wr && (wb_adr_i == A_CNT)) |=> $stable(q.cnt);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved in idle");
    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");

    c_latch: cover property (q.hold && !q.flt[B_FMODE] ##1 !q.hold);
    c_cbc: cover property (q.hold && q.flt[B_FMODE] ##1 !q.hold);
    c_trig: cover property (adc_trigger_o);
    c_lock: cover property (q.upd[B_LOCK] && wr && wb_adr_i == A_DC1);
endmodule // pfl_top
`default_nettype wire

/* verif/pfl_fault_src.sv */
`timescale 1ns/1ns
`default_nettype none
// External fault detector: drives the low-active fault line, fast or slow
module pfl_fault_src #(
    parameter int DLY = 3
) (
    input wire logic clk_i, // System clock
    input wire logic trip_i, // Fault condition seen by detector
    input wire logic slow_i, // Respond after DLY cycles
    output logic fault_input_n_o // Fault line, low active
);
    logic [3:0] cnt = 4'h0;
    logic lvl = 1'b0;

    // Slow mode holds off each change, like a filtered comparator
    always @(posedge clk_i) begin
        if (trip_i == lvl) begin
            cnt <= 4'h0;
        end else if (!slow_i || cnt == 4'(DLY)) begin
            lvl <= trip_i;
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Push-pull line, always driven
    assign fault_input_n_o = ~lvl;
endmodule // pfl_fault_src
`default_nettype wire

/* verif/tb_pfl_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_pfl_top;
    import pfl_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic idle_i = 1'b0, sleep_i = 1'b0, trip = 1'b0, slow = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, fault_n, fault_flag_o, adc_trigger_o;
    logic [5:0] pwm_o, pwm_en_o, fst;
    logic [31:0] exp_q[$];
    logic [31:0] rs = 32'h5a;
    int miscompares = 0, samples_checked = 0, i, r, cnt;
    logic [9:0] ridx[13] = '{RI_TBC, RI_CNT, RI_PER, RI_CMP, RI_PMC, RI_UPD, RI_DTC,
        RI_FLT, RI_OVD, RI_DC1, RI_DC2, RI_DC3, RI_CFG};
    logic [15:0] rval[13] = '{RV_ZERO, RV_ZERO, RV_PER, RV_ZERO, RV_PMC, RV_ZERO, RV_ZERO,
        RV_ZERO, RV_OVD, RV_ZERO, RV_ZERO, RV_ZERO, 16'h0003};

    always #20 clk_i = ~clk_i;

    pfl_fault_src #(.DLY(3)) u_src (.clk_i(clk_i), .trip_i(trip), .slow_i(slow),
        .fault_input_n_o(fault_n));

    pfl_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_input_n_i(fault_n),
        .idle_i(idle_i), .sleep_i(sleep_i), .pwm_o(pwm_o), .pwm_en_o(pwm_en_o),
        .fault_flag_o(fault_flag_o), .adc_trigger_o(adc_trigger_o));

    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Pin levels: forced state on enabled pairs, else normal, then side polarity
    function logic [5:0] exp_pins(logic [2:0] en, logic [5:0] st, logic [1:0] pol,
        logic [5:0] norm);
        logic a, p;
        for (int k = 0; k < 6; k++) begin
            a = en[k/2] ? st[k] : norm[k];
            p = (k % 2) ? pol[0] : pol[1];
            exp_pins[k] = a ? p : ~p;
        end
    endfunction

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task test_done;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Classic single cycle; entered just after a rising edge
    task bus(logic [9:0] idx, logic we, logic [15:0] d);
        int n;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {16'h0, d};
        wb_sel_i <= 4'h3;
        wb_we_i <= we;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 50) begin
            miscompares++;
            test_done;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task rd(logic [9:0] idx, logic [15:0] e);
        exp_q.push_back({16'h0, e});
        bus(idx, 1'b0, 16'h0);
    endtask

    task settle;
        repeat (14) @(posedge clk_i);
    endtask

    task count_pulses(int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (adc_trigger_o === 1'b1) cnt++;
        end
    endtask

    // Read results are compared in order of issue, at the ack edge
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) check("read_unexpected", 32'h1, 32'h0);
            else check("wb_dat_o", wb_dat_o, exp_q.pop_front());
        end
    end

    // Bound on the whole run
    initial begin
        #4000000;
        miscompares++;
        test_done;
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 13; i++) rd(ridx[i], rval[i]);
        bus(10'h1cf, 1'b1, 16'(rnd()));
        rd(10'h1cf, 16'h0);
        for (i = 0; i < 3; i++) begin
            fst = 6'(rnd());
            bus(RI_DC2, 1'b1, {fst, fst, 4'h5});
            rd(RI_DC2, {fst, fst, 4'h5});
        end
        // Duty two back to zero so pair two shows the idle levels
        bus(RI_DC2, 1'b1, 16'h0000);
        settle;
        check("pwm_en_o", pwm_en_o, 6'h3f);
        check("pwm_idle", pwm_o, exp_pins(3'h0, 6'h0, 2'h3, 6'h15));
        // Fault in sleep with no pair enabled
        sleep_i <= 1'b1;
        trip <= 1'b1;
        settle;
        check("flag_sleep", fault_flag_o, 1'b1);
        check("pwm_unforced", pwm_o, exp_pins(3'h0, 6'h0, 2'h3, 6'h15));
        trip <= 1'b0;
        sleep_i <= 1'b0;
        settle;
        bus(RI_STAT, 1'b1, 16'h0001);
        check("flag_clear", fault_flag_o, 1'b0);
        // Latched mode on pairs 1 and 3
        fst = 6'(rnd());
        bus(RI_FLT, 1'b1, {2'b00, fst, 8'h05});
        trip <= 1'b1;
        settle;
        check("pwm_forced", pwm_o, exp_pins(3'h5, fst, 2'h3, 6'h15));
        rd(RI_STAT, 16'h0005);
        bus(RI_CFG, 1'b1, 16'h0001);
        settle;
        check("pwm_pol", pwm_o, exp_pins(3'h5, fst, 2'h1, 6'h15));
        bus(RI_STAT, 1'b1, 16'h0001);
        settle;
        check("pwm_early_clr", pwm_o, exp_pins(3'h5, fst, 2'h1, 6'h15));
        trip <= 1'b0;
        settle;
        check("pwm_latched", pwm_o, exp_pins(3'h5, fst, 2'h1, 6'h15));
        bus(RI_STAT, 1'b1, 16'h0001);
        settle;
        check("pwm_release", pwm_o, exp_pins(3'h0, fst, 2'h1, 6'h15));
        rd(RI_STAT, 16'h0002);
        // Cycle-by-cycle mode, slow detector, all pairs
        bus(RI_FLT, 1'b1, {2'b00, fst, 8'h87});
        slow <= 1'b1;
        trip <= 1'b1;
        settle;
        check("pwm_cyc_forced", pwm_o, exp_pins(3'h7, fst, 2'h1, 6'h15));
        trip <= 1'b0;
        settle;
        check("pwm_cyc_release", pwm_o, exp_pins(3'h0, fst, 2'h1, 6'h15));
        check("flag_kept", fault_flag_o, 1'b1);
        slow <= 1'b0;
        bus(RI_STAT, 1'b1, 16'h0001);
        // Update lockout with time base stopped
        bus(RI_DC1, 1'b1, 16'h0010);
        settle;
        check("high1_on", pwm_o[1], 1'b1);
        bus(RI_UPD, 1'b1, 16'h0001);
        bus(RI_DC1, 1'b1, 16'h0000);
        settle;
        check("high1_locked", pwm_o[1], 1'b1);
        rd(RI_DC1, 16'h0000);
        bus(RI_UPD, 1'b1, 16'h0000);
        settle;
        check("high1_off", pwm_o[1], 1'b0);
        // Every postscale ratio; direction bit toggled in free mode
        for (r = 0; r < 16; r++) begin
            bus(RI_TBC, 1'b1, 16'h0000);
            bus(RI_UPD, 1'b1, 16'(r << 8));
            bus(RI_PER, 1'b1, 16'h0009);
            bus(RI_CMP, 1'b1, {r[0], 15'h0005});
            bus(RI_CNT, 1'b1, 16'h0000);
            bus(RI_TBC, 1'b1, 16'h8000);
            count_pulses(20 * (r + 1) + 2);
            check("trig_count", cnt, 2);
        end
        // Idle stop halts, idle run continues
        idle_i <= 1'b1;
        bus(RI_UPD, 1'b1, 16'h0000);
        bus(RI_TBC, 1'b1, 16'ha000);
        count_pulses(50);
        check("trig_idle_stop", cnt, 0);
        bus(RI_TBC, 1'b1, 16'h8000);
        count_pulses(50);
        check("trig_idle_run", cnt, 5);
        idle_i <= 1'b0;
        // Running edge mode: duty moves at period match, never under lockout
        bus(RI_UPD, 1'b1, 16'h0001);
        bus(RI_DC1, 1'b1, 16'h0010);
        cnt = 0;
        repeat (30) begin
            @(posedge clk_i);
            if (pwm_o[1] === 1'b1) cnt++;
        end
        check("high1_run_locked", cnt, 0);
        bus(RI_UPD, 1'b1, 16'h0000);
        settle;
        cnt = 0;
        repeat (20) begin
            @(posedge clk_i);
            if (pwm_o[1] === 1'b1) cnt++;
        end
        check("high1_run_duty", cnt, 16);
        // Up/down, single then double update: phase of first trigger from zero
        for (i = 0; i < 4; i++) begin
            bus(RI_TBC, 1'b1, 16'h0000);
            bus(RI_CMP, 1'b1, {i[0], 15'h0005});
            bus(RI_CNT, 1'b1, 16'h0000);
            bus(RI_TBC, 1'b1, {15'h4001, i[1]});
            for (r = 0; r < 60; r++) begin
                @(posedge clk_i);
                if (adc_trigger_o === 1'b1) break;
            end
            check("trig_phase", 32'(i[0] ? (r >= 11 && r < 60) : (r < 10)), 32'h1);
        end
        test_done;
    end
endmodule // tb_pfl_top
`default_nettype wire
